//--- core/flash_cycle.sv
// Purpose: one asynchronous flash read or write cycle, timed in mclk cycles
// Assumes: start is only honoured while idle is high
// Notes:   chip enable rises at the end of every cycle, so each read is a fresh read cycle
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
  import flash_host_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire cyc_req_t     req,
  input  wire logic [7:0]   dq_i,
  output logic              idle,
  output logic              done,
  output logic [7:0]        rdata,
  output flash_pins_t       pins
);

  // ************************************************
  // sequencer
  // ************************************************
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;

  phase_t      phase_q;
  logic [7:0]  cnt_q;
  logic        we_q;

  assign idle = (phase_q == PH_IDLE);

  // phases: setup, strobe low, hold with strobe high, then release
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_q      <= PH_IDLE;
      cnt_q        <= 8'h00;
      we_q         <= 1'b0;
      done         <= 1'b0;
      rdata        <= RDATA_RST;
      pins.ce_n    <= 1'b1;
      pins.oe_n    <= 1'b1;
      pins.we_n    <= 1'b1;
      pins.addr    <= ADDR_RST;
      pins.dq_o    <= WDATA_RST;
      pins.dq_oe   <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (phase_q)
        PH_IDLE: begin
          if (start) begin
            we_q       <= req.we;
            pins.addr  <= req.addr;
            pins.dq_o  <= req.data;
            pins.dq_oe <= req.we;
            pins.ce_n  <= 1'b0;
            cnt_q      <= SETUP_CYC - 8'h01;
            phase_q    <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_q == 8'h00) begin
            pins.oe_n <= we_q;
            pins.we_n <= ~we_q;
            cnt_q     <= we_q ? (WP_CYC - 8'h01) : (ACC_CYC - 8'h01);
            phase_q   <= PH_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PH_STROBE: begin
          if (cnt_q == 8'h00) begin
            if (!we_q) begin
              rdata <= dq_i;  // sampled at the end of the full access time
            end
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;  // this rising edge is what makes status valid
            cnt_q     <= HOLD_CYC - 8'h01;
            phase_q   <= PH_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PH_HOLD: begin
          if (cnt_q == 8'h00) begin
            pins.ce_n  <= 1'b1;
            pins.dq_oe <= 1'b0;
            done       <= 1'b1;
            phase_q    <= PH_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          phase_q <= PH_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- core/flash_host_pkg.sv
// Purpose: shared constants and types for the flash status-polling host controller
// Assumes: 100 MHz mclk, byte-wide flash bus, APB register access
// Notes:   every offset, status and data-line bit position, data reset value and timing count lives here
package flash_host_pkg;

  // ************************************************
  // clock and flash bus timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS    = 10;   // address and chip enable ahead of the strobe
  localparam int T_ACC_NS      = 120;  // slowest access time of the part family
  localparam int T_WP_NS       = 50;   // write strobe low time
  localparam int T_HOLD_NS     = 30;   // address and data hold after the strobe rises

  // least times, so they round up to whole cycles
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WP_CYC    = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC  = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ************************************************
  // widths
  // ************************************************
  localparam int FADDR_W = 21;
  localparam int FDATA_W = 8;

  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_ADDR   = 12'h004;
  localparam logic [11:0] OFF_WDATA  = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_RDATA  = 12'h010;

  // status bit positions
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_MISMATCH = 3;
  localparam int ST_READY    = 4;
  localparam int ST_ERASE_TM = 5;
  localparam int ST_SUSP     = 6;
  localparam int ST_NEED_RST = 7;

  // data line positions inside a status read
  localparam int DQ_POLL  = 7;
  localparam int DQ_TOG1  = 6;
  localparam int DQ_LIMIT = 5;
  localparam int DQ_TIMER = 3;
  localparam int DQ_TOG2  = 2;

  // reset values and the erased byte value
  localparam logic [FADDR_W-1:0] ADDR_RST  = 21'h000000;
  localparam logic [FDATA_W-1:0] WDATA_RST = 8'h00;
  localparam logic [FDATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [FDATA_W-1:0] ERASED_VAL = 8'hff;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [2:0] {
    OP_NONE,
    OP_WRITE,
    OP_READ,
    OP_POLL_DATA,
    OP_POLL_TOGGLE
  } op_t;

  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] addr;
    logic [FDATA_W-1:0] data;
  } cyc_req_t;

  typedef struct packed {
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
    logic [FADDR_W-1:0] addr;
    logic [FDATA_W-1:0] dq_o;
    logic               dq_oe;
  } flash_pins_t;

endpackage

//--- core/flash_status_host.sv
// Purpose: host-side controller that writes to a parallel flash and polls its operation status
// Assumes: software sends command sequences as single write cycles, then starts a poll
// Notes:   APB slave for orders and status; flash pins are sampled as synchronous inputs
//
// Notes on behaviour
// - program polling reads the program address; bit 7 inverted until done.
// - erase polling bit reads 0 then 1; read inside an erasing sector.
// - after polling bit settles, read once more for valid low byte.
// - in suspend, other sectors read array data; program only outside erase set.
// - after a timing-limit failure the host must send the reset command.
// - bit 5 counts only while polling or toggle bit shows busy.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_status_host
  import flash_host_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // flash pins
  input  wire logic                ready_busy_out,
  input  wire logic [FDATA_W-1:0]  dq_i,
  output logic                     flash_ce_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n,
  output logic [FADDR_W-1:0]       flash_addr,
  output logic [FDATA_W-1:0]       flash_dq_o,
  output logic                     flash_dq_oe
);

  // ************************************************
  // declarations
  // ************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_WRITE, S_READ, S_DP, S_DP_RE, S_TG_A, S_TG_B, S_TG_A2, S_TG_B2, S_FINAL
  } state_t;

  state_t              state_q;
  op_t                 mode_q;
  logic                issued_q;
  logic [FADDR_W-1:0]  addr_q;
  logic [FDATA_W-1:0]  wdata_q;
  logic [FDATA_W-1:0]  rdata_q;
  logic [FDATA_W-1:0]  first_q;
  logic                ready_q;
  logic                done_q;
  logic                fail_q;
  logic                mism_q;
  logic                susp_q;
  logic                need_rst_q;
  logic                lat_q;
  logic [31:0]         prdata_q;
  logic                perr_q;

  logic                cyc_start;
  logic                cyc_idle;
  logic                cyc_done;
  logic [FDATA_W-1:0]  cyc_rdata;
  cyc_req_t            cyc_req;
  flash_pins_t         pins;

  logic                wr_access;
  logic                go;
  op_t                 go_op;
  logic                ev_done;
  logic                ev_fail;
  logic                ev_mism;
  logic                ev_susp;
  logic                ev_wr_done;
  logic [7:0]          status_vec;

  // ************************************************
  // decode helpers
  // ************************************************
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_ADDR) || (a == OFF_WDATA) ||
                (a == OFF_STATUS) || (a == OFF_RDATA);
  endfunction

  // accepted orders; the write cycle is always allowed so the reset command can go out
  function automatic logic op_ok(input logic [2:0] v, input logic blocked);
    op_ok = (v == OP_WRITE) ||
            (!blocked && ((v == OP_READ) || (v == OP_POLL_DATA) || (v == OP_POLL_TOGGLE)));
  endfunction

  // ************************************************
  // apb slave
  // ************************************************
  // read data is latched in the setup cycle so the access phase drives it from flops
  assign pready    = psel & penable & clk_en & lat_q;
  assign prdata    = prdata_q;
  assign pslverr   = perr_q & pready;
  assign wr_access = pready & pwrite;

  assign status_vec = {need_rst_q, susp_q, rdata_q[DQ_TIMER], ready_q,  // erase timer seen
                       mism_q, fail_q, done_q, (state_q != S_IDLE)};

  // setup-phase latch of read data and error
  always_ff @(posedge mclk) begin
    if (srst) begin
      lat_q    <= 1'b0;
      prdata_q <= 32'h00000000;
      perr_q   <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        lat_q  <= 1'b1;
        perr_q <= ~is_mapped(paddr);
        case (paddr)
          OFF_CTRL:   prdata_q <= {29'h00000000, mode_q};
          OFF_ADDR:   prdata_q <= {11'h000, addr_q};
          OFF_WDATA:  prdata_q <= {24'h000000, wdata_q};
          OFF_STATUS: prdata_q <= {24'h000000, status_vec};
          OFF_RDATA:  prdata_q <= {24'h000000, rdata_q};
          default:    prdata_q <= 32'h00000000;
        endcase
      end else if (pready) begin
        lat_q <= 1'b0;
      end
    end
  end

  // address and write-data registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_q  <= ADDR_RST;
      wdata_q <= WDATA_RST;
    end else if (clk_en && wr_access) begin
      if (paddr == OFF_ADDR) begin
        addr_q <= pwdata[FADDR_W-1:0];
      end
      if (paddr == OFF_WDATA) begin
        wdata_q <= pwdata[FDATA_W-1:0];
      end
    end
  end

  // an order is taken only while idle; polls are refused until a write clears the lock
  assign go    = wr_access && (paddr == OFF_CTRL) && (state_q == S_IDLE) &&
                 op_ok(pwdata[2:0], need_rst_q);
  assign go_op = op_t'(pwdata[2:0]);

  // ************************************************
  // poll evaluation events
  // ************************************************
  // decides, at the end of each flash cycle, what the sampled status means
  always_comb begin
    ev_done    = 1'b0;
    ev_fail    = 1'b0;
    ev_mism    = 1'b0;
    ev_susp    = 1'b0;
    ev_wr_done = 1'b0;
    if (cyc_done) begin
      case (state_q)
        S_WRITE: begin
          ev_done    = 1'b1;
          ev_wr_done = 1'b1;
        end
        S_READ: begin
          ev_done = 1'b1;
        end
        S_DP_RE: begin
          // bit 7 may have settled together with bit 5, so only a second miss is a failure
          ev_fail = (cyc_rdata[DQ_POLL] != wdata_q[DQ_POLL]);
          ev_done = ev_fail;
        end
        S_TG_B: begin
          // a still bit 6 with a moving bit 2 marks a sector selected for erase
          ev_susp = (cyc_rdata[DQ_TOG1] == first_q[DQ_TOG1]) &&
                    (cyc_rdata[DQ_TOG2] != first_q[DQ_TOG2]);
        end
        S_TG_B2: begin
          ev_fail = (cyc_rdata[DQ_TOG1] != first_q[DQ_TOG1]);
          ev_susp = !ev_fail && (cyc_rdata[DQ_TOG2] != first_q[DQ_TOG2]);
          ev_done = ev_fail;
        end
        S_FINAL: begin
          ev_done = 1'b1;
          // protected targets return old array data, which shows up here as a mismatch on data polls only
          ev_mism = (mode_q == OP_POLL_DATA) && (cyc_rdata != wdata_q);
        end
        default: begin
          ev_done = 1'b0;
        end
      endcase
    end
  end

  // ************************************************
  // status flags
  // ************************************************
  // write-one-to-clear; a new event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      mism_q <= 1'b0;
      susp_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_access && (paddr == OFF_STATUS)) begin
        done_q <= ev_done | (done_q & ~pwdata[ST_DONE]);
        fail_q <= ev_fail | (fail_q & ~pwdata[ST_FAIL]);
        mism_q <= ev_mism | (mism_q & ~pwdata[ST_MISMATCH]);
        susp_q <= ev_susp | (susp_q & ~pwdata[ST_SUSP]);
      end else begin
        done_q <= done_q | ev_done;
        fail_q <= fail_q | ev_fail;
        mism_q <= mism_q | ev_mism;
        susp_q <= susp_q | ev_susp;
      end
    end
  end

  // failure lock, lifted by the next completed write cycle (the reset command)
  always_ff @(posedge mclk) begin
    if (srst) begin
      need_rst_q <= 1'b0;
    end else if (clk_en) begin
      if (ev_fail) begin
        need_rst_q <= 1'b1;
      end else if (ev_wr_done) begin
        need_rst_q <= 1'b0;
      end
    end
  end

  // ready/busy pin mirrored into status; open-drain level is resolved outside
  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_q <= 1'b1;
    end else if (clk_en) begin
      ready_q <= ready_busy_out;
    end
  end

  // ************************************************
  // poll sequencer
  // ************************************************
  // a poll is only started by a later order, so it always follows the final write strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q  <= S_IDLE;
      mode_q   <= OP_NONE;
      issued_q <= 1'b0;
      rdata_q  <= RDATA_RST;
      first_q  <= RDATA_RST;
    end else if (clk_en) begin
      if (cyc_start) begin
        issued_q <= 1'b1;
      end else if (cyc_done) begin
        issued_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (go) begin
            mode_q <= go_op;
            case (go_op)
              OP_WRITE:       state_q <= S_WRITE;
              OP_READ:        state_q <= S_READ;
              OP_POLL_DATA:   state_q <= S_DP;
              OP_POLL_TOGGLE: state_q <= S_TG_A;
              default:        state_q <= S_IDLE;
            endcase
          end
        end
        S_WRITE: begin
          if (cyc_done) begin
            state_q <= S_IDLE;
          end
        end
        S_READ: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;  // in suspend this is plain array data outside the erase set
            state_q <= S_IDLE;
          end
        end
        S_DP: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            // true bit 7 (or 1 for erase, with expected data all ones) ends the poll
            if (cyc_rdata[DQ_POLL] == wdata_q[DQ_POLL]) begin
              state_q <= S_FINAL;
            end else if (cyc_rdata[DQ_LIMIT]) begin
              state_q <= S_DP_RE;
            end
          end
        end
        S_DP_RE: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            state_q <= ev_fail ? S_IDLE : S_FINAL;
          end
        end
        S_TG_A: begin
          if (cyc_done) begin
            first_q <= cyc_rdata;
            rdata_q <= cyc_rdata;
            state_q <= S_TG_B;
          end
        end
        S_TG_B: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            first_q <= cyc_rdata;  // slide the pair so each read is compared to the last
            if (cyc_rdata[DQ_TOG1] == first_q[DQ_TOG1]) begin
              state_q <= S_FINAL;
            end else if (cyc_rdata[DQ_LIMIT]) begin
              state_q <= S_TG_A2;
            end
          end
        end
        S_TG_A2: begin
          if (cyc_done) begin
            first_q <= cyc_rdata;
            rdata_q <= cyc_rdata;
            state_q <= S_TG_B2;
          end
        end
        S_TG_B2: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            state_q <= ev_fail ? S_IDLE : S_FINAL;
          end
        end
        S_FINAL: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;  // the extra read gives all eight bits settled
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // flash cycle engine
  // ************************************************
  // every status read goes to the order address: program address or erasing sector
  assign cyc_start    = (state_q != S_IDLE) && !issued_q && cyc_idle;
  assign cyc_req.we   = (state_q == S_WRITE);
  assign cyc_req.addr = addr_q;
  assign cyc_req.data = wdata_q;

  flash_cycle u_cycle (
    .mclk   (mclk),
    .srst   (srst),
    .clk_en (clk_en),
    .start  (cyc_start),
    .req    (cyc_req),
    .dq_i   (dq_i),
    .idle   (cyc_idle),
    .done   (cyc_done),
    .rdata  (cyc_rdata),
    .pins   (pins)
  );

  assign flash_ce_n  = pins.ce_n;
  assign flash_oe_n  = pins.oe_n;
  assign flash_we_n  = pins.we_n;
  assign flash_addr  = pins.addr;
  assign flash_dq_o  = pins.dq_o;
  assign flash_dq_oe = pins.dq_oe;

endmodule
`default_nettype wire

//--- tb/flash_host_chk.sv
// Purpose: port checker for the flash status host
// Assumes: clk_en stays high, so cycle counts are exact
// Notes:   bound to the flash_status_host module by the bind below
`timescale 1ns/1ps
`default_nettype none
module flash_host_chk
  import flash_host_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_dq_oe
);
  // ************************************************
  // bus and strobe relations
  // ************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  AST_APB_ZERO_WAIT:
    assert property (clk_en && psel && !penable ##1 psel && penable |-> pready) else $error("late pready");
  AST_UNMAPPED:
    assert property (psel && penable && pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFF_RDATA))
      else $error("pslverr wrong");
  // reset must leave every strobe parked high
  AST_RESET_IDLE:
    assert property (disable iff (1'b0) srst |=> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe)
      else $error("strobes active after reset");
  AST_WE_WIDTH:
    assert property ($fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n) else $error("write strobe width");
  AST_OE_WIDTH:
    assert property ($fell(flash_oe_n) |-> !flash_oe_n[*8] ##1 !flash_oe_n[*4] ##1 flash_oe_n)
      else $error("read strobe width");
  AST_CE_SETUP:
    assert property ($fell(flash_ce_n) |-> flash_oe_n && flash_we_n ##1 !flash_ce_n) else $error("no setup");
  AST_HOLD:
    assert property ($rose(flash_oe_n) || $rose(flash_we_n) |-> !flash_ce_n ##[2:4] flash_ce_n)
      else $error("hold wrong");
  AST_NO_CONTENTION:
    assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("bus contention");
  AST_WE_DRIVES:
    assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("write without data");
endmodule
bind flash_status_host flash_host_chk flash_host_chk_i (.mclk(mclk), .srst(srst), .clk_en(clk_en),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

//--- tb/flash_model.sv
// Purpose: behavioural flash part answering status reads
// Assumes: bench picks the next algorithm kind and its length in reads
// Notes:   kind 0 program, 1 erase, 2 stuck with timing-limit failure
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic       ce_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  input  wire logic [7:0] dq_o,
  input  wire logic       dq_oe,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] len,
  output logic            rb,
  output logic [7:0]      dq_i
);
  // ************************************************
  // algorithm state
  // ************************************************
  logic [7:0] val_q  = 8'hff;
  logic [7:0] left_q = 8'h00;
  logic       tog_q  = 1'b0;
  logic [7:0] st;
  logic [7:0] dat;
  // algorithm starts at the write strobe's rising edge
  always @(posedge we_n) begin
    if (!ce_n && dq_oe) begin
      val_q  <= (kind == 2'd1) ? 8'hff : dq_o;
      left_q <= len;
      tog_q  <= 1'b0;
    end
  end
  // each finished read while busy flips toggle bit 6, and bit 2 as well for erase
  always @(posedge oe_n) begin
    if (!ce_n && left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
      tog_q  <= ~tog_q;
    end
  end
  // polling, toggle one, limit, erase timer, toggle two
  // limit bit is only shown while busy, so it never outlives the algorithm
  assign st   = (kind == 2'd1) ? {1'b0, tog_q, 1'b0, val_q[4], 1'b1, tog_q, val_q[1:0]}
                               : {~val_q[7], tog_q, kind == 2'd2, val_q[4:0]};
  assign dat  = (left_q != 8'h00) ? st : val_q;
  // released lines show the inverse so a stale value never passes
  assign dq_i = (!ce_n && !oe_n) ? dat : ~dat;
  // open drain pulled low while busy, pull-up otherwise
  assign rb   = (left_q == 8'h00);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the flash status host
// Assumes: apb tasks wait for pready, watchdog cuts hangs
// Notes:   program, erase and failing runs under both poll kinds
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_host_pkg::*;
  // ************************************************
  // signals and instances
  // ************************************************
  logic mclk, srst, clk_en, psel, penable, pwrite, pready, pslverr, err_q, rb;
  logic ce_n, oe_n, we_n, dq_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ad;
  logic [7:0]  dq_i, dq_o, len, d, e, wd;
  logic [1:0]  kind;
  logic [FADDR_W-1:0] fa;
  int seed, mismatches, checked, i;
  flash_status_host flash_status_host_i (.mclk(mclk), .srst(srst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ready_busy_out(rb), .dq_i(dq_i), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe));
  flash_model flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_o(dq_o), .dq_oe(dq_oe),
    .kind(kind), .len(len), .rb(rb), .dq_i(dq_i));
  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status polled under a bound; the last read stays in rd
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 400);
    check(32'(n >= 400), 32'h0);
  endtask
  function automatic logic [31:0] exp_st(input logic fail, input logic mism);
    exp_st = 32'h0;
    exp_st[ST_DONE] = 1'b1;
    exp_st[ST_FAIL] = fail;
    exp_st[ST_MISMATCH] = mism;
    exp_st[ST_NEED_RST] = fail;
    exp_st[ST_READY] = ~fail;
  endfunction
  // ************************************************
  // tests
  // ************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clk_en, srst, kind, len, seed} = {1'b1, 1'b1, 2'd0, 8'h00, 32'd76};
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h10);
    apb(1'b1, 12'h020, $random(seed));
    check({rd[30:0], err_q}, 32'h1);
    for (i = 0; i < 12; i++) begin
      kind <= 2'(i % 3);
      len <= (i % 3 == 2) ? 8'hff : 8'(1 + {$random(seed)} % 8);
      d = $random(seed);
      e = (i % 3 == 1) ? 8'hff : d;
      wd = e ^ 8'(i % 6 == 0);
      ad = $random(seed);
      apb(1'b1, OFF_ADDR, ad);
      apb(1'b1, OFF_WDATA, {24'h0, d});
      apb(1'b1, OFF_CTRL, 32'h1);
      wait_idle();
      check(32'(rd[ST_READY]), 32'h0);
      if (i % 3 == 1) begin
        apb(1'b1, OFF_CTRL, 32'h2);
        wait_idle();
        check(32'(rd[ST_ERASE_TM]), 32'h1);
      end
      apb(1'b1, OFF_STATUS, 32'hff);
      apb(1'b1, OFF_WDATA, {24'h0, wd});
      apb(1'b1, OFF_CTRL, (i % 6 < 3) ? 32'h3 : 32'h4);
      wait_idle();
      check(rd & 32'h9f, exp_st(i % 3 == 2, wd != e && i % 3 != 2));
      check({11'h0, fa}, {11'h0, ad[FADDR_W-1:0]});
      apb(1'b0, OFF_RDATA, 32'h0);
      check((i % 3 == 2) ? 32'(rd[DQ_LIMIT]) : rd, (i % 3 == 2) ? 32'h1 : {24'h0, e});
      if (i % 3 == 2) begin
        apb(1'b1, OFF_STATUS, 32'hff);
        apb(1'b1, OFF_CTRL, 32'h3);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'h83, 32'h80);
        len <= 8'h00;
        apb(1'b1, OFF_CTRL, 32'h1);
        wait_idle();
        check(rd & 32'h91, 32'h10);
      end
      $display("test %0d done", i);
    end
    final_report();
  end
  // watchdog sized well beyond the twelve runs
  initial begin
    #500000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
